// ===== src/dcp_port.sv
/*
  debug command port: decodes command bytes from the debug pin link,
  keeps the debug control byte and the debug counter, raises halts.
  assumes bytes arrive already deserialised, one-cycle strobes, same clock.
*/
// How it works
// - counter runs outside debug mode, stops in debug mode or at all-ones
// - in cycle-count use counter clears to zero on leaving debug mode
// - command 03 returns inverted counter, high byte then low
// - command 03 outside debug mode returns all ones
// - command 04 plus one byte loads the debug control register
// - under read protect the halt bit may be set but never cleared
// - command 05 returns the debug control byte
// - command 06 loads program counter unless running or read protected
// - command 07 returns program counter or all ones when barred
// - command 08: address high, address low, size (0 means 256), data
// - write-register outside debug mode takes bytes but writes nothing
// - under read protect only flash control registers may be written
// - break opcode: loop select clear sets halt, set loops on it
// - pc match select sets halt when program counter equals counter
// - with pc match select the counter holds while running
// - count-zero break sets halt when counter decrements to zero
// - self-reset bit resets the device but not the debugger
// - self-reset bit clears when the device reset finishes
// - clearing loop select while looping halts on return to opcode
`timescale 1ns/1ps
`default_nettype none
module dcp_port
  import dcp_pkg::*;
(
  input  wire logic        ref_clk,         // system clock, 20 MHz
  input  wire logic        rst,             // async reset, high
  input  wire logic        rx_valid,        // byte from host, pulse
  input  wire logic [7:0]  rx_data,         // byte from host
  input  wire logic        read_protect,    // read protect option
  input  wire logic [15:0] cpu_pc,          // cpu program counter
  input  wire logic        break_decoded,   // break opcode decoded, pulse
  input  wire logic        device_reset_done, // system reset sequence over
  output logic             tx_valid,        // byte to host, pulse
  output logic [7:0]       tx_data,         // byte to host
  output logic             pc_load,         // load program counter, pulse
  output logic [15:0]      pc_load_value,   // new program counter
  output logic             reg_write,       // register file write, pulse
  output logic [11:0]      reg_addr,        // register file address
  output logic [7:0]       reg_data,        // register file data
  output logic             debug_halt_flag, // cpu halted in debug mode
  output logic             loop_on_break,   // cpu loops on break opcode
  output logic             system_reset_req, // reset all but debugger
  output logic [7:0]       debug_control    // control byte
);
  typedef enum logic [3:0] {
    DCP_IDLE, DCP_CTL_DATA, DCP_PC_HIGH, DCP_PC_LOW, DCP_ADDR_HIGH,
    DCP_ADDR_LOW, DCP_SIZE, DCP_DATA, DCP_SEND_LOW
  } dcp_state_t;

  dcp_state_t  state;
  dcp_state_t  next_state;
  logic [7:0]  next_debug_control;
  logic [7:0]  low_byte;
  logic [7:0]  next_low_byte;
  logic [7:0]  pc_high;
  logic [7:0]  next_pc_high;
  logic [8:0]  remaining;
  logic [8:0]  next_remaining;
  logic [11:0] next_reg_addr;
  logic [11:0] wr_ptr;
  logic [11:0] next_wr_ptr;
  logic        next_tx_valid;
  logic [7:0]  next_tx_data;
  logic        next_pc_load;
  logic [15:0] next_pc_load_value;
  logic        next_reg_write;
  logic [7:0]  next_reg_data;
  logic        next_loop_on_break;
  logic        next_system_reset_req;
  logic        looping;
  logic        next_looping;
  logic        halt_d;
  logic [15:0] cnt_raw;
  logic        cnt_run;
  logic        cnt_clear;
  logic [15:0] cnt_up;
  logic        in_debug;
  logic        halt;
  logic        use_pc;
  logic        use_zero;
  logic        hit_pc;
  logic        hit_zero;
  logic        reg_allowed;

  assign halt     = debug_control[DCP_BIT_HALT];
  assign use_pc   = debug_control[DCP_BIT_PC_MATCH];
  assign use_zero = debug_control[DCP_BIT_COUNT_ZERO];
  assign in_debug = halt;
  assign cnt_up   = ~cnt_raw;

  // counter runs only while cpu runs, not in pc-match use, not saturated
  assign cnt_run   = !halt && !use_pc && cnt_up != DCP_COUNTER_MAX;
  // clear on exit from debug mode unless count-zero break or pc-match use keeps it
  assign cnt_clear = halt_d && !halt && !use_zero && !use_pc;
  assign hit_pc    = use_pc && !halt && cpu_pc == cnt_up;
  assign hit_zero  = use_zero && cnt_run && cnt_up == 16'hfffe;

  dcp_counter u_counter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (cnt_run),
    .clear   (cnt_clear),
    .value   (cnt_raw)
  );

  // window check on the address this data byte will land on
  always_comb begin
    reg_allowed = !read_protect ||
                  (wr_ptr >= DCP_FLASH_CTL_LOW && wr_ptr <= DCP_FLASH_CTL_HIGH);
  end

  always_comb begin
    next_state            = state;
    next_debug_control    = debug_control;
    next_low_byte         = low_byte;
    next_pc_high          = pc_high;
    next_remaining        = remaining;
    next_reg_addr         = reg_addr;
    next_wr_ptr           = wr_ptr;
    next_tx_valid         = 1'b0;
    next_tx_data          = tx_data;
    next_pc_load          = 1'b0;
    next_pc_load_value    = pc_load_value;
    next_reg_write        = 1'b0;
    next_reg_data         = reg_data;
    next_looping          = looping;
    next_system_reset_req = system_reset_req;

    // self-reset bit drives the system reset, not this block's reset
    next_system_reset_req = debug_control[DCP_BIT_SELF_RESET];
    if (device_reset_done && system_reset_req) begin
      next_debug_control[DCP_BIT_SELF_RESET] = 1'b0;
    end

    unique case (state)
      DCP_IDLE: begin
        if (rx_valid) begin
          unique case (rx_data)
            DCP_CMD_READ_COUNTER: begin
              next_tx_valid = 1'b1;
              next_tx_data  = in_debug ? cnt_up[15:8] : DCP_ALL_ONES[15:8];
              next_low_byte = in_debug ? cnt_up[7:0] : DCP_ALL_ONES[7:0];
              next_state    = DCP_SEND_LOW;
            end
            DCP_CMD_WRITE_CONTROL: next_state = DCP_CTL_DATA;
            DCP_CMD_READ_CONTROL: begin
              next_tx_valid = 1'b1;
              next_tx_data  = debug_control;
            end
            DCP_CMD_WRITE_PC: next_state = DCP_PC_HIGH;
            DCP_CMD_READ_PC: begin
              next_tx_valid = 1'b1;
              if (in_debug && !read_protect) begin
                next_tx_data  = cpu_pc[15:8];
                next_low_byte = cpu_pc[7:0];
              end else begin
                next_tx_data  = DCP_ALL_ONES[15:8];
                next_low_byte = DCP_ALL_ONES[7:0];
              end
              next_state = DCP_SEND_LOW;
            end
            DCP_CMD_WRITE_REG: next_state = DCP_ADDR_HIGH;
            default: next_state = DCP_IDLE;
          endcase
        end
      end
      DCP_SEND_LOW: begin
        next_tx_valid = 1'b1;
        next_tx_data  = low_byte;
        next_state    = DCP_IDLE;
      end
      DCP_CTL_DATA: begin
        if (rx_valid) begin
          next_debug_control = rx_data;
          next_debug_control[DCP_BIT_RESERVED] = 1'b0;
          if (read_protect && halt) begin
            next_debug_control[DCP_BIT_HALT] = 1'b1;
          end
          next_state = DCP_IDLE;
        end
      end
      DCP_PC_HIGH: begin
        if (rx_valid) begin
          next_pc_high = rx_data;
          next_state   = DCP_PC_LOW;
        end
      end
      DCP_PC_LOW: begin
        if (rx_valid) begin
          next_pc_load_value = {pc_high, rx_data};
          next_pc_load       = in_debug && !read_protect;
          next_state         = DCP_IDLE;
        end
      end
      DCP_ADDR_HIGH: begin
        if (rx_valid) begin
          next_wr_ptr   = {rx_data[3:0], wr_ptr[7:0]};
          next_state    = DCP_ADDR_LOW;
        end
      end
      DCP_ADDR_LOW: begin
        if (rx_valid) begin
          next_wr_ptr   = {wr_ptr[11:8], rx_data};
          next_state    = DCP_SIZE;
        end
      end
      DCP_SIZE: begin
        if (rx_valid) begin
          next_remaining = (rx_data == 8'h00) ? DCP_SIZE_ZERO_MEANS
                                              : {1'b0, rx_data};
          next_state     = DCP_DATA;
        end
      end
      DCP_DATA: begin
        if (rx_valid) begin
          // pointer steps on every byte, dropped ones included
          next_reg_data  = rx_data;
          next_reg_addr  = wr_ptr;
          next_wr_ptr    = wr_ptr + 12'h001;
          next_reg_write = in_debug && reg_allowed;
          next_remaining = remaining - 9'h001;
          if (remaining == 9'h001) begin
            next_state = DCP_IDLE;
          end
        end
      end
      default: next_state = DCP_IDLE;
    endcase

    // hardware halt requests come last: they win over a host
    // write of the control byte landing in the same cycle
    if (break_decoded && debug_control[DCP_BIT_BREAK_ENABLE] && !halt) begin
      if (debug_control[DCP_BIT_LOOP_SELECT]) begin
        next_looping = 1'b1;
      end else begin
        next_debug_control[DCP_BIT_HALT] = 1'b1;
        next_looping = 1'b0;
      end
    end
    if (!debug_control[DCP_BIT_LOOP_SELECT] && looping && break_decoded) begin
      next_debug_control[DCP_BIT_HALT] = 1'b1;
      next_looping = 1'b0;
    end
    if (hit_pc || hit_zero) begin
      next_debug_control[DCP_BIT_HALT] = 1'b1;
    end
    next_loop_on_break = next_looping;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state            <= DCP_IDLE;
      debug_control    <= DCP_CONTROL_RESET;
      low_byte         <= 8'h00;
      pc_high          <= 8'h00;
      remaining        <= 9'h000;
      reg_addr         <= 12'h000;
      wr_ptr           <= 12'h000;
      tx_valid         <= 1'b0;
      tx_data          <= 8'h00;
      pc_load          <= 1'b0;
      pc_load_value    <= 16'h0000;
      reg_write        <= 1'b0;
      reg_data         <= 8'h00;
      looping          <= 1'b0;
      loop_on_break    <= 1'b0;
      system_reset_req <= 1'b0;
      debug_halt_flag  <= 1'b0;
      halt_d           <= 1'b0;
    end else begin
      state            <= next_state;
      debug_control    <= next_debug_control;
      low_byte         <= next_low_byte;
      pc_high          <= next_pc_high;
      remaining        <= next_remaining;
      reg_addr         <= next_reg_addr;
      wr_ptr           <= next_wr_ptr;
      tx_valid         <= next_tx_valid;
      tx_data          <= next_tx_data;
      pc_load          <= next_pc_load;
      pc_load_value    <= next_pc_load_value;
      reg_write        <= next_reg_write;
      reg_data         <= next_reg_data;
      looping          <= next_looping;
      loop_on_break    <= next_loop_on_break;
      system_reset_req <= next_system_reset_req;
      debug_halt_flag  <= next_debug_control[DCP_BIT_HALT];
      halt_d           <= halt;
    end
  end
endmodule // dcp_port
`default_nettype wire

// ===== src/dcp_pkg.sv
/*
  constants for the debug counter and command port: command codes,
  control field positions, reset values, sizes.
  assumes nothing of its surroundings.
*/
package dcp_pkg;
  localparam logic [7:0]  DCP_CMD_READ_COUNTER  = 8'h03;
  localparam logic [7:0]  DCP_CMD_WRITE_CONTROL = 8'h04;
  localparam logic [7:0]  DCP_CMD_READ_CONTROL  = 8'h05;
  localparam logic [7:0]  DCP_CMD_WRITE_PC      = 8'h06;
  localparam logic [7:0]  DCP_CMD_READ_PC       = 8'h07;
  localparam logic [7:0]  DCP_CMD_WRITE_REG     = 8'h08;
  localparam int          DCP_BIT_HALT          = 7;
  localparam int          DCP_BIT_BREAK_ENABLE  = 5;
  localparam int          DCP_BIT_LOOP_SELECT   = 4;
  localparam int          DCP_BIT_PC_MATCH      = 3;
  localparam int          DCP_BIT_COUNT_ZERO    = 2;
  localparam int          DCP_BIT_RESERVED      = 1;
  localparam int          DCP_BIT_SELF_RESET    = 0;
  localparam logic [7:0]  DCP_CONTROL_RESET     = 8'h00;
  localparam logic [15:0] DCP_COUNTER_RESET     = 16'h0000;
  localparam logic [15:0] DCP_COUNTER_MAX       = 16'hffff;
  localparam logic [15:0] DCP_ALL_ONES          = 16'hffff;
  localparam logic [8:0]  DCP_SIZE_ZERO_MEANS   = 9'h100;
  // flash control register window kept writable under read protection
  localparam logic [11:0] DCP_FLASH_CTL_LOW     = 12'hff8;
  localparam logic [11:0] DCP_FLASH_CTL_HIGH    = 12'hffb;
endpackage

// ===== src/dcp_counter.sv
/*
  16-bit debug cycle counter: counts down while running, stored
  inverted so software reads an up count; clearable.
  assumes run and clear from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dcp_counter
  import dcp_pkg::*;
(
  input  wire logic        ref_clk,    // system clock
  input  wire logic        rst,        // async reset, high
  input  wire logic        run,        // count one cycle
  input  wire logic        clear,      // return to start value
  output logic [15:0]      value       // raw down-count value
);
  logic [15:0] next_value;

  always_comb begin
    next_value = value;
    if (clear) begin
      next_value = DCP_COUNTER_MAX;  // reads as 0000 once inverted
    end else if (run && value != 16'h0000) begin
      next_value = value - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      value <= DCP_COUNTER_MAX;
    end else begin
      value <= next_value;
    end
  end
endmodule // dcp_counter
`default_nettype wire

// ===== testbench/dcp_chk_assertions.sv
/* checker for the debug command port, bound to dcp_port.
   assumes one clock domain, rst async active high. */
`timescale 1ns/1ps
`default_nettype none
module dcp_chk (
  input wire logic        ref_clk,           // clock
  input wire logic        rst,               // reset
  input wire logic        rx_valid,          // host strobe
  input wire logic        read_protect,      // protect option
  input wire logic        break_decoded,     // break decode
  input wire logic        device_reset_done, // reset over
  input wire logic        tx_valid,          // reply strobe
  input wire logic        pc_load,           // pc write
  input wire logic        reg_write,         // reg write
  input wire logic [11:0] reg_addr,          // reg address
  input wire logic        debug_halt_flag,   // halted
  input wire logic        loop_on_break,     // looping
  input wire logic        system_reset_req,  // reset request
  input wire logic [7:0]  debug_control      // control byte
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_halt; debug_halt_flag == debug_control[7]; endproperty
  a_halt: assert property (p_halt) else $error("halt flag differs");
  property p_reply; tx_valid |-> $past(rx_valid) || $past(tx_valid); endproperty
  a_reply: assert property (p_reply) else $error("reply without command");
  property p_prot;
    read_protect && $past(read_protect) && $past(debug_control[7]) |-> debug_control[7];
  endproperty
  a_prot: assert property (p_prot) else $error("halt cleared under protect");
  property p_rsvd; debug_control[1] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_pc; pc_load |-> $past(debug_control[7]) && !$past(read_protect); endproperty
  a_pc: assert property (p_pc) else $error("pc load while barred");
  property p_wr; reg_write |-> $past(debug_control[7]); endproperty
  a_wr: assert property (p_wr) else $error("write while running");
  property p_flash;
    reg_write && $past(read_protect) |-> reg_addr inside {[12'hff8:12'hffb]};
  endproperty
  a_flash: assert property (p_flash) else $error("protected write");
  property p_seq; reg_write && $past(reg_write) |-> reg_addr == $past(reg_addr) + 12'h001;
  endproperty
  a_seq: assert property (p_seq) else $error("address not successive");
  property p_brk;
    break_decoded && debug_control[5] && !debug_control[4] |-> ##[1:2] debug_halt_flag;
  endproperty
  a_brk: assert property (p_brk) else $error("break did not halt");
  property p_sreq; $rose(debug_control[0]) |-> ##[1:2] system_reset_req; endproperty
  a_sreq: assert property (p_sreq) else $error("no reset request");
  property p_sclr; system_reset_req && device_reset_done |-> ##[1:2] !debug_control[0];
  endproperty
  a_sclr: assert property (p_sclr) else $error("self reset bit stuck");
  c_wr: cover property (reg_write);
  c_pc: cover property (pc_load);
  c_loop: cover property (loop_on_break);
  c_sreq: cover property (system_reset_req);
endmodule // dcp_chk
bind dcp_port dcp_chk u_chk (.ref_clk, .rst, .rx_valid, .read_protect, .break_decoded,
  .device_reset_done, .tx_valid, .pc_load, .reg_write, .reg_addr, .debug_halt_flag,
  .loop_on_break, .system_reset_req, .debug_control);
`default_nettype wire

// ===== testbench/dcp_host.sv
/* debug host model: sends byte sequences, collects reply bytes.
   assumes bytes already deserialised, same clock as the port. */
`timescale 1ns/1ps
`default_nettype none
module dcp_host (
  input  wire logic       ref_clk,  // clock
  input  wire logic       tx_valid, // reply strobe
  input  wire logic [7:0] tx_data,  // reply byte
  output logic            rx_valid, // byte strobe
  output logic [7:0]      rx_data   // byte to port
);
  logic [7:0] replies[$];
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1) replies.push_back(tx_data);
  end
  // command then its bytes, back to back; idle line shows inverse
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= q[i];
      @(posedge ref_clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~q[q.size() - 1];
  endtask
  task automatic wctl(input logic [7:0] v);
    send('{8'h04, v & 8'hfd});
  endtask
endmodule // dcp_host
`default_nettype wire

// ===== testbench/debug_counter_command_port_bench.sv
/* bench for dcp_port: random and corner command sequences.
   assumes dcp_host model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module debug_counter_command_port_bench;
  import dcp_pkg::*;
  logic        ref_clk, rst, rx_valid, read_protect, break_decoded, rdone;
  logic        tx_valid, pc_load, reg_write, halt, loop, sreq;
  logic [7:0]  rx_data, tx_data, reg_data, ctl;
  logic [11:0] reg_addr;
  logic [15:0] cpu_pc, pc_val, pc_last;
  logic [19:0] wq[$];
  logic [31:0] seed = 32'h658bd6a4;
  int          miscompares = 0, check_count = 0, pc_cnt = 0;
  dcp_port dut (.ref_clk, .rst, .rx_valid, .rx_data, .read_protect, .cpu_pc,
    .break_decoded, .device_reset_done(rdone), .tx_valid, .tx_data, .pc_load,
    .pc_load_value(pc_val), .reg_write, .reg_addr, .reg_data, .debug_halt_flag(halt),
    .loop_on_break(loop), .system_reset_req(sreq), .debug_control(ctl));
  dcp_host host (.ref_clk, .tx_valid, .tx_data, .rx_valid, .rx_data);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (reg_write === 1'b1) wq.push_back({reg_addr, reg_data});
    if (pc_load === 1'b1) begin
      pc_cnt++;
      pc_last <= pc_val;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_pc(input logic h, p, input logic [15:0] v);
    return (h && !p) ? v : DCP_ALL_ONES;
  endfunction
  function automatic logic [7:0] exp_ctl(input logic [7:0] o, w, input logic p);
    return {w[7] | (p & o[7]), w[6:2], 1'b0, w[0]};
  endfunction
  task automatic rnd(output logic [15:0] r);
    seed = lfsr(seed);
    r = seed[15:0];
  endtask
  task automatic results();
    if (miscompares == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [19:0] e, a);
    check_count++;
    if (a !== e) begin
      miscompares++;
      $display("Error %0t exp %h got %h", $time, e, a);
    end
  endtask
  task automatic chk_in(input logic [15:0] lo, hi, a);
    check_count++;
    if ((a >= lo && a <= hi) !== 1'b1) begin
      miscompares++;
      $display("Error %0t exp %h..%h got %h", $time, lo, hi, a);
    end
  endtask
  task automatic cmd(input logic [7:0] q[$]);
    host.send(q);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic wc(input logic [7:0] v);
    host.wctl(v);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] r);
    host.replies.delete();
    cmd('{c});
    r = 'x;
    if (host.replies.size() == n)
      r = (n == 2) ? {host.replies[0], host.replies[1]} : {8'h00, host.replies[0]};
  endtask
  task automatic wreg(input logic [11:0] ad, input logic [7:0] sz, input logic ok);
    logic [7:0]  q[$];
    logic [15:0] d;
    int          n;
    n = (sz == 8'h00) ? 256 : int'(sz);
    q = '{DCP_CMD_WRITE_REG, {4'h0, ad[11:8]}, ad[7:0], sz};
    wq.delete();
    for (int i = 0; i < n; i++) begin
      rnd(d);
      q.push_back(d[7:0]);
    end
    cmd(q);
    chk(ok ? 20'(n) : 20'h0, 20'(wq.size()));
    foreach (wq[i]) chk({ad + 12'(i), q[i + 4]}, wq[i]);
  endtask
  task automatic wpc(input logic [15:0] p, input int e);
    pc_cnt = 0;
    cmd('{DCP_CMD_WRITE_PC, p[15:8], p[7:0]});
    chk(20'(e), 20'(pc_cnt));
  endtask
  task automatic pulse();
    break_decoded <= 1'b1;
    @(posedge ref_clk);
    break_decoded <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    results();
  end
  initial begin : main
    logic [15:0] r, a, b, p;
    rst = 1'b1;
    read_protect = 1'b0;
    break_decoded = 1'b0;
    rdone = 1'b0;
    cpu_pc = 16'h0000;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(DCP_CMD_READ_CONTROL, 1, r);
    chk(16'h0000, r);
    rd(DCP_CMD_READ_COUNTER, 2, r);
    chk(DCP_ALL_ONES, r);
    rd(DCP_CMD_READ_PC, 2, r);
    chk(exp_pc(1'b0, 1'b0, 16'h0000), r);
    wc(8'h80);
    wc(8'h00);
    repeat (40) @(posedge ref_clk);
    wc(8'h80);
    rd(DCP_CMD_READ_COUNTER, 2, a);
    chk_in(16'd40, 16'd56, a);
    repeat (20) @(posedge ref_clk);
    rd(DCP_CMD_READ_COUNTER, 2, r);
    chk(a, r);
    wc(8'h84);
    wc(8'h04);
    repeat (40) @(posedge ref_clk);
    wc(8'h84);
    rd(DCP_CMD_READ_COUNTER, 2, b);
    chk_in(a + 16'd40, a + 16'd56, b);
    wc(8'h88);
    wc(8'h08);
    repeat (40) @(posedge ref_clk);
    wc(8'h88);
    rd(DCP_CMD_READ_COUNTER, 2, r);
    chk(b, r);
    cpu_pc <= b;
    wc(8'h08);
    chk(1'b1, halt);
    wc(8'h80);
    rnd(p);
    cpu_pc <= p;
    rd(DCP_CMD_READ_PC, 2, r);
    chk(exp_pc(1'b1, 1'b0, p), r);
    rnd(p);
    wpc(p, 1);
    chk(p, pc_last);
    wreg(12'h200, 8'h00, 1'b1);
    rnd(a);
    wreg(a[11:0] & 12'h7ff, {5'h00, a[14:12]} + 8'h01, 1'b1);
    read_protect <= 1'b1;
    wreg(12'hff8, 8'h04, 1'b1);
    wreg(12'h100, 8'h02, 1'b0);
    rd(DCP_CMD_READ_PC, 2, r);
    chk(exp_pc(1'b1, 1'b1, p), r);
    wpc(p, 0);
    wc(8'h00);
    rd(DCP_CMD_READ_CONTROL, 1, r);
    chk(exp_ctl(8'h80, 8'h00, 1'b1), r);
    read_protect <= 1'b0;
    wc(8'h00);
    wreg(12'h300, 8'h03, 1'b0);
    wpc(p, 0);
    wc(8'h20);
    pulse();
    chk(1'b1, halt);
    wc(8'h30);
    pulse();
    chk(2'b10, {loop, halt});
    wc(8'h20);
    pulse();
    chk(1'b1, halt);
    wc(8'h81);
    chk(2'b11, {sreq, halt});
    rdone <= 1'b1;
    @(posedge ref_clk);
    rdone <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(DCP_CMD_READ_CONTROL, 1, r);
    chk(16'h0080, r);
    chk(8'h80, ctl);
    wc(8'h00);
    wc(8'h04);
    for (int i = 0; i < 70000 && halt !== 1'b1; i++) @(posedge ref_clk);
    chk(1'b1, halt);
    rd(DCP_CMD_READ_COUNTER, 2, r);
    chk(DCP_COUNTER_MAX, r);
    rnd(a);
    wc({1'b1, a[6:2], 2'b00});
    rd(DCP_CMD_READ_CONTROL, 1, r);
    chk(exp_ctl(8'h84, {1'b1, a[6:2], 2'b00}, 1'b0), r);
    chk(exp_ctl(8'h84, {1'b1, a[6:2], 2'b00}, 1'b0), ctl);
    results();
  end
endmodule // debug_counter_command_port_bench
`default_nettype wire
